// File: hw/cswk_pkg.sv
// Functional notes
// RULE1 - control bit 7 enables oscillator calibration
// RULE2 - trim unlock only with pattern 11
// RULE3 - unlock gates low-power receiver option writes
// RULE4 - bit 4 routes bus time-out to interrupt
// RULE5 - time-out flag updates only in wake mode
// RULE6 - host sets valid bit to enable wake
// RULE7 - valid cleared on wake, reset, config change
// RULE8 - reserved bits always read as zero
// RULE9 - eight-bit quanta count per bit time
// RULE10 - six-bit sample point fraction below one
// RULE11 - 29-bit identifier split over four registers
// RULE12 - standard identifier sits in bits 28 to 18
// RULE13 - bit 1 selects data or remote frame
// RULE14 - host never programs remote request to one
// RULE15 - bit 0 selects standard or extended format
// RULE16 - mask bit one compares identifier bit
// RULE17 - wake frame needs valid, flags, masked bits
package cswk_pkg;
   // register offsets
   localparam logic [7:0] CSWK_OFS_CTRL = 8'h20;
   localparam logic [7:0] CSWK_OFS_QUANTA = 8'h21;
   localparam logic [7:0] CSWK_OFS_SAMPLE = 8'h22;
   localparam logic [7:0] CSWK_OFS_ID3 = 8'h23;
   localparam logic [7:0] CSWK_OFS_ID2 = 8'h24;
   localparam logic [7:0] CSWK_OFS_ID1 = 8'h25;
   localparam logic [7:0] CSWK_OFS_ID0 = 8'h26;
   localparam logic [7:0] CSWK_OFS_MASK3 = 8'h27;
   localparam logic [7:0] CSWK_OFS_OPT = 8'h28;
   localparam logic [7:0] CSWK_OFS_IRQ_STAT = 8'h30;
   localparam logic [7:0] CSWK_OFS_IRQ_MASK = 8'h31;
   // reset values
   localparam logic [7:0] CSWK_RST_CTRL = 8'h00;
   localparam logic [7:0] CSWK_RST_QUANTA = 8'hA0;
   localparam logic [5:0] CSWK_RST_SAMPLE = 6'h33;
   localparam logic [7:0] CSWK_RST_ID = 8'h00;
   localparam logic [7:0] CSWK_RST_OPT = 8'h00;
   localparam logic [2:0] CSWK_RST_IRQ = 3'h0;
   // control field positions
   localparam int CSWK_CTRL_CAL = 7;
   localparam int CSWK_CTRL_TRIM_HI = 6;
   localparam int CSWK_CTRL_TRIM_LO = 5;
   localparam int CSWK_CTRL_TO_IRQ = 4;
   localparam int CSWK_CTRL_VALID = 0;
   localparam logic [1:0] CSWK_TRIM_UNLOCK = 2'h3;
   // identifier byte 0 field positions
   localparam int CSWK_ID0_RTR = 1;
   localparam int CSWK_ID0_IDE = 0;
   // interrupt status bit positions
   localparam int CSWK_IRQ_TIMEOUT = 0;
   localparam int CSWK_IRQ_WAKE = 1;
   localparam int CSWK_IRQ_CFGCLR = 2;
endpackage

// File: hw/cswk_matcher.sv
`timescale 1ns/1ps
// compares a received frame header against the wake configuration
module cswk_matcher
   import cswk_pkg::*;
(
   input wire logic [28:0] ident, // configured identifier
   input wire logic [7:0] compare_high, // compare select for bits 28:21
   input wire logic rtr, // configured frame type
   input wire logic ide, // configured identifier format
   input wire logic cfg_valid, // configuration valid
   input wire logic [28:0] rx_ident, // received identifier
   input wire logic rx_rtr, // received frame type
   input wire logic rx_ide, // received format
   output logic hit // frame qualifies as wake frame
);
   logic [28:0] sel; // per-bit compare select
   logic [28:0] diff; // per-bit mismatch

   // only the top byte carries a compare select here; lower bits compare always
   genvar gi;
   generate
      for (gi = 0; gi < 29; gi++) begin : g_bit
         if (gi >= 21) begin : g_sel
            assign sel[gi] = compare_high[gi - 21]; // RULE16
         end else begin : g_all
            assign sel[gi] = 1'b1;
         end
         assign diff[gi] = sel[gi] & (ident[gi] ^ rx_ident[gi]);
      end
   endgenerate

   // standard frames match only bits 28:18, so lower bits are dropped
   always_comb begin
      logic [28:0] used;
      used = ide ? diff : {diff[28:18], 18'h0}; // RULE15 RULE12
      hit = cfg_valid & (rtr == rx_rtr) & (ide == rx_ide) & ~|used; // RULE17 RULE13
   end
endmodule

// File: hw/cswk_config.sv
`timescale 1ns/1ps
module cswk_config
   import cswk_pkg::*;
(
   input wire logic clk, // 25 MHz clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [7:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic wake_mode, // selective wake mode active
   input wire logic bus_timeout, // time-out event pulse
   input wire logic wake_event, // device woke up, pulse
   input wire logic bus_transmit_input_pin, // transmit pin, asynchronous
   input wire logic rx_valid, // received header valid pulse
   input wire logic [28:0] rx_ident, // received identifier
   input wire logic rx_rtr, // received frame type
   input wire logic rx_ide, // received format
   output logic wakeup_frame, // wake frame matched, pulse
   output logic bus_timeout_flag, // sticky time-out status
   output logic interrupt_out_pin, // level interrupt
   output logic oscillator_calibration_enable, // calibration mode active
   output logic trim_sync_ref, // synchronised trim reference
   output logic low_power_rx_enable, // alternative receiver enable
   output logic [7:0] quanta_per_bit, // quanta per bit time
   output logic [5:0] sample_point_position // sample point fraction
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [1:0] trim_unlock; // calibration unlock field
   logic bus_timeout_irq_enable; // route time-out to pin
   logic wake_config_valid; // configuration valid
   logic [7:0] ident_bits_high; // identifier 28:21
   logic [7:0] ident_bits_midhigh; // identifier 20:13
   logic [7:0] ident_bits_midlow; // identifier 12:5
   logic [4:0] ident_bits_low; // identifier 4:0
   logic frame_rtr; // expected frame type
   logic frame_ide; // expected format
   logic [7:0] ident_compare_select_high; // compare select 28:21
   logic [7:0] low_power_receiver_option_register; // option register
   logic [2:0] irq_status; // sticky events
   logic [2:0] irq_mask; // event enables
   logic [1:0] txd_sync; // transmit pin synchroniser
   logic unlocked; // trim unlock active
   logic cfg_write; // write to configuration data
   logic match_hit; // combinational match
   logic [2:0] events; // event pulses this cycle
   logic stat_read; // status read clears

   assign unlocked = (trim_unlock == CSWK_TRIM_UNLOCK); // RULE2
   assign stat_read = rd && (addr == CSWK_OFS_IRQ_STAT);
   // any write to identifier, timing or mask data counts as a change
   assign cfg_write = wr && (addr >= CSWK_OFS_QUANTA) && (addr <= CSWK_OFS_MASK3);

   ////////////////////////////////////////////////////////////////////////
   // matcher
   cswk_matcher u_match (
      .ident({ident_bits_high, ident_bits_midhigh, ident_bits_midlow, ident_bits_low}),
      .compare_high(ident_compare_select_high),
      .rtr(frame_rtr),
      .ide(frame_ide),
      .cfg_valid(wake_config_valid),
      .rx_ident(rx_ident),
      .rx_rtr(rx_rtr),
      .rx_ide(rx_ide),
      .hit(match_hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge clk) begin
      if (rst) begin
         oscillator_calibration_enable <= CSWK_RST_CTRL[CSWK_CTRL_CAL];
         trim_unlock <= CSWK_RST_CTRL[CSWK_CTRL_TRIM_HI:CSWK_CTRL_TRIM_LO];
         bus_timeout_irq_enable <= CSWK_RST_CTRL[CSWK_CTRL_TO_IRQ];
      end else if (wr && addr == CSWK_OFS_CTRL) begin
         oscillator_calibration_enable <= wdata[CSWK_CTRL_CAL]; // RULE1
         trim_unlock <= wdata[CSWK_CTRL_TRIM_HI:CSWK_CTRL_TRIM_LO]; // RULE2
         bus_timeout_irq_enable <= wdata[CSWK_CTRL_TO_IRQ]; // RULE4
      end
   end

   // valid bit: cleared by wake, reset and config change; clear wins
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_config_valid <= CSWK_RST_CTRL[CSWK_CTRL_VALID]; // RULE7
      end else if (wake_event || cfg_write) begin
         wake_config_valid <= 1'b0; // RULE7
      end else if (wr && addr == CSWK_OFS_CTRL) begin
         wake_config_valid <= wdata[CSWK_CTRL_VALID]; // RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit timing registers
   always_ff @(posedge clk) begin
      if (rst) begin
         quanta_per_bit <= CSWK_RST_QUANTA;
         sample_point_position <= CSWK_RST_SAMPLE;
      end else if (wr) begin
         if (addr == CSWK_OFS_QUANTA) begin
            quanta_per_bit <= wdata; // RULE9
         end
         if (addr == CSWK_OFS_SAMPLE) begin
            sample_point_position <= wdata[5:0]; // RULE10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // identifier and mask registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ident_bits_high <= CSWK_RST_ID;
         ident_bits_midhigh <= CSWK_RST_ID;
         ident_bits_midlow <= CSWK_RST_ID;
         ident_bits_low <= CSWK_RST_ID[6:2];
         frame_rtr <= CSWK_RST_ID[CSWK_ID0_RTR];
         frame_ide <= CSWK_RST_ID[CSWK_ID0_IDE];
         ident_compare_select_high <= CSWK_RST_ID;
      end else if (wr) begin
         unique case (addr)
            CSWK_OFS_ID3: begin
               ident_bits_high <= wdata; // RULE11
            end
            CSWK_OFS_ID2: begin
               ident_bits_midhigh <= wdata; // RULE11
            end
            CSWK_OFS_ID1: begin
               ident_bits_midlow <= wdata; // RULE11
            end
            CSWK_OFS_ID0: begin
               ident_bits_low <= wdata[6:2]; // RULE11
               frame_rtr <= wdata[CSWK_ID0_RTR]; // RULE13
               frame_ide <= wdata[CSWK_ID0_IDE]; // RULE15
            end
            CSWK_OFS_MASK3: begin
               ident_compare_select_high <= wdata; // RULE16
            end
            default: begin
               // other addresses leave identifier data alone
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // option register, writable only while unlocked
   always_ff @(posedge clk) begin
      if (rst) begin
         low_power_receiver_option_register <= CSWK_RST_OPT;
      end else if (wr && addr == CSWK_OFS_OPT && unlocked) begin
         low_power_receiver_option_register <= wdata; // RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_power_rx_enable <= 1'b0;
      end else begin
         low_power_rx_enable <= low_power_receiver_option_register[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit pin synchroniser, used as trim reference while unlocked
   always_ff @(posedge clk) begin
      if (rst) begin
         txd_sync <= 2'h0;
      end else begin
         txd_sync <= {txd_sync[0], bus_transmit_input_pin};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trim_sync_ref <= 1'b0;
      end else begin
         trim_sync_ref <= unlocked & txd_sync[1]; // RULE2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake frame pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         wakeup_frame <= 1'b0;
      end else begin
         wakeup_frame <= rx_valid & match_hit; // RULE17
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky events; set wins over read clear
   always_comb begin
      events = 3'h0;
      events[CSWK_IRQ_TIMEOUT] = bus_timeout & wake_mode; // RULE5
      events[CSWK_IRQ_WAKE] = rx_valid & match_hit;
      events[CSWK_IRQ_CFGCLR] = wake_config_valid & (wake_event | cfg_write);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= CSWK_RST_IRQ;
      end else if (stat_read) begin
         irq_status <= events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask <= CSWK_RST_IRQ;
      end else if (wr && addr == CSWK_OFS_IRQ_MASK) begin
         irq_mask <= wdata[2:0];
      end
   end

   // time-out flag updated only in wake mode
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_timeout_flag <= 1'b0;
      end else if (wake_mode) begin
         bus_timeout_flag <= bus_timeout | (bus_timeout_flag & ~stat_read); // RULE5
      end
   end

   // time-out reaches the pin only when routed
   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_out_pin <= 1'b0;
      end else begin
         interrupt_out_pin <= |(irq_status & irq_mask & {2'h3, bus_timeout_irq_enable}); // RULE4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data; reserved bits read zero, unmapped reads zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            CSWK_OFS_CTRL: begin
               rdata <= {oscillator_calibration_enable, trim_unlock, bus_timeout_irq_enable,
                         3'h0, wake_config_valid}; // RULE8
            end
            CSWK_OFS_QUANTA: begin
               rdata <= quanta_per_bit;
            end
            CSWK_OFS_SAMPLE: begin
               rdata <= {2'h0, sample_point_position}; // RULE8
            end
            CSWK_OFS_ID3: begin
               rdata <= ident_bits_high;
            end
            CSWK_OFS_ID2: begin
               rdata <= ident_bits_midhigh;
            end
            CSWK_OFS_ID1: begin
               rdata <= ident_bits_midlow;
            end
            CSWK_OFS_ID0: begin
               rdata <= {1'b0, ident_bits_low, frame_rtr, frame_ide}; // RULE8
            end
            CSWK_OFS_MASK3: begin
               rdata <= ident_compare_select_high;
            end
            CSWK_OFS_OPT: begin
               rdata <= low_power_receiver_option_register;
            end
            CSWK_OFS_IRQ_STAT: begin
               rdata <= {5'h0, irq_status};
            end
            CSWK_OFS_IRQ_MASK: begin
               rdata <= {5'h0, irq_mask};
            end
            default: begin
               rdata <= 8'h00;
            end
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// File: test/cswk_config_properties.sv
`timescale 1ns/1ps
module cswk_props
   import cswk_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic [7:0] addr, // address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic wake_mode, // wake mode
   input wire logic wake_event, // woke up
   input wire logic rx_valid, // header valid
   input wire logic wakeup_frame, // match pulse
   input wire logic bus_timeout_flag, // time-out status
   input wire logic oscillator_calibration_enable, // calibration
   input wire logic [7:0] quanta_per_bit, // quanta
   input wire logic [5:0] sample_point_position // sample point
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////
   // register side
   property p_rsvd_ctrl; rd && addr == CSWK_OFS_CTRL |=> rdata[3:1] == 3'h0; endproperty
   a_rsvd_ctrl: assert property (p_rsvd_ctrl) else $error("control spare bits set");
   property p_rsvd_id0; rd && addr == CSWK_OFS_ID0 |=> !rdata[7]; endproperty
   a_rsvd_id0: assert property (p_rsvd_id0) else $error("ident spare bit set");
   property p_cal;
      wr && addr == CSWK_OFS_CTRL |=> oscillator_calibration_enable == $past(wdata[7]);
   endproperty
   a_cal: assert property (p_cal) else $error("calibration enable wrong");
   property p_quanta; wr && addr == CSWK_OFS_QUANTA |=> quanta_per_bit == $past(wdata); endproperty
   a_quanta: assert property (p_quanta) else $error("quanta wrong");
   property p_sample;
      wr && addr == CSWK_OFS_SAMPLE |=> sample_point_position == $past(wdata[5:0]);
   endproperty
   a_sample: assert property (p_sample) else $error("sample point wrong");
   ////////////////////////////////
   // wake side
   property p_valid_clr;
      wake_event ##1 (!wr && !rx_valid) ##1 (rx_valid && !wr) |=> !wakeup_frame;
   endproperty
   a_valid_clr: assert property (p_valid_clr) else $error("match after wake");
   // a reset at the previous edge may legally move the flag, so skip that edge
   property p_flag_hold;
      !$past(wake_mode) && !$past(rst) |-> bus_timeout_flag == $past(bus_timeout_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved outside mode");
   property p_frame; wakeup_frame |-> $past(rx_valid); endproperty
   a_frame: assert property (p_frame) else $error("match without header");
endmodule
bind cswk_config cswk_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .wake_mode(wake_mode), .wake_event(wake_event), .rx_valid(rx_valid),
   .wakeup_frame(wakeup_frame), .bus_timeout_flag(bus_timeout_flag),
   .oscillator_calibration_enable(oscillator_calibration_enable),
   .quanta_per_bit(quanta_per_bit), .sample_point_position(sample_point_position));

// File: test/cswk_host.sv
`timescale 1ns/1ps
module cswk_host (
   input wire logic clk, // clock
   input wire logic [7:0] rdata, // read data
   output logic [7:0] addr = 8'h00, // address
   output logic [7:0] wdata = 8'h00, // write data
   output logic wr = 1'b0, // write strobe
   output logic rd = 1'b0 // read strobe
);
   // one-cycle write, remote request never set, bus scrambled after
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= (a == 8'h26) ? (d & 8'hFD) : d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   // one-cycle read, data taken in the next cycle
   task automatic r(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask
   // control register written with the valid bit forced to one
   task automatic arm(input logic [7:0] c);
      w(8'h20, c | 8'h01);
   endtask
endmodule

// File: test/can_selective_wake_config_tb.sv
`timescale 1ns/1ps
module can_selective_wake_config_tb;
   import cswk_pkg::*;
   logic clk = 1'b0; // 25 MHz clock
   logic rst = 1'b1; // reset
   logic [7:0] addr, wdata, rdata, quanta, d;
   logic wr, rd, hitq, flag, irq, cal, trim, lp;
   logic wake_mode = 1'b0, bus_timeout = 1'b0, wake_event = 1'b0, tx_pin = 1'b0;
   logic rx_valid = 1'b0, rx_rtr = 1'b0, rx_ide = 1'b0;
   logic [28:0] rx_ident = 29'h0;
   logic [5:0] sp;
   logic [7:0] m [8'h20:8'h27]; // register model
   int err_count = 0;
   int compares = 0;
   int seed = 32'h4CB4;
   int k;
   always #20 clk = ~clk;
   cswk_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   cswk_config DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .wake_mode(wake_mode), .bus_timeout(bus_timeout), .wake_event(wake_event),
      .bus_transmit_input_pin(tx_pin), .rx_valid(rx_valid), .rx_ident(rx_ident),
      .rx_rtr(rx_rtr), .rx_ide(rx_ide), .wakeup_frame(hitq), .bus_timeout_flag(flag),
      .interrupt_out_pin(irq), .oscillator_calibration_enable(cal), .trim_sync_ref(trim),
      .low_power_rx_enable(lp), .quanta_per_bit(quanta), .sample_point_position(sp));
   ////////////////////////////////
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // register write mirrored in the model
   task w(input logic [7:0] a, input logic [7:0] v);
      u_host.w(a, v);
      if (a >= 8'h20 && a <= 8'h27) m[a] = v & (a == 8'h20 ? 8'hF1 : a == 8'h22 ? 8'h3F :
         a == 8'h26 ? 8'h7D : 8'hFF);
      if (a > 8'h20 && a <= 8'h27) m[8'h20][0] = 1'b0;
   endtask
   task rc(input logic [7:0] a);
      u_host.r(a, d);
      chk("rdata", (a >= 8'h20 && a <= 8'h27) ? m[a] : 8'h00, d);
   endtask
   function logic [28:0] cfgid();
      return {m[8'h23], m[8'h24], m[8'h25], m[8'h26][6:2]};
   endfunction
   // header presented for one cycle, match seen in the next
   task frm(input logic [28:0] id, input logic r, input logic e);
      logic [28:0] mk;
      logic x;
      mk = m[8'h26][0] ? {m[8'h27], 21'h1FFFFF} : {m[8'h27], 3'h7, 18'h0};
      x = m[8'h20][0] && r == m[8'h26][1] && e == m[8'h26][0] && ((cfgid() ^ id) & mk) == 0;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_ident <= id;
      rx_rtr <= r;
      rx_ide <= e;
      @(posedge clk);
      rx_valid <= 1'b0;
      #1;
      chk("wakeup_frame", x, hitq);
   endtask
   task tmo(input logic wm);
      @(posedge clk);
      wake_mode <= wm;
      bus_timeout <= 1'b1;
      @(posedge clk);
      bus_timeout <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////
   initial begin
      for (int i = 8'h20; i <= 8'h27; i++) m[i] = 8'h00;
      m[8'h21] = 8'hA0;
      m[8'h22] = 8'h33;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int a = 8'h20; a <= 8'h27; a++) rc(8'(a));
      rc(8'h40);
      for (int a = 8'h21; a <= 8'h27; a++) begin
         w(8'(a), 8'($random(seed)));
         rc(8'(a));
      end
      chk("quanta", m[8'h21], quanta);
      chk("sample", m[8'h22][5:0], sp);
      w(8'h20, 8'h9F);
      rc(8'h20);
      chk("cal", 1, cal);
      // both formats, single-bit flips, frame type and format misses
      for (int f = 0; f < 2; f++) begin
         w(8'h26, (8'($random(seed)) & 8'h7C) | 8'(f));
         u_host.arm(8'h91);
         m[8'h20] = 8'h91;
         for (int i = 0; i < 12; i++) begin
            k = $random(seed) & 31;
            // standard identifiers sit in bits 28:18, flips below that must still match
            frm(cfgid() ^ (k < 29 ? 29'h1 << k : 29'h0), i % 5 == 4,
               f[0] ^ (i % 7 == 6));
         end
      end
      w(8'h23, m[8'h23]);
      rc(8'h20);
      frm(cfgid(), 1'b0, 1'b1);
      u_host.arm(8'h91);
      m[8'h20] = 8'h91;
      @(posedge clk);
      wake_event <= 1'b1;
      @(posedge clk);
      wake_event <= 1'b0;
      m[8'h20][0] = 1'b0;
      frm(cfgid(), 1'b0, 1'b1);
      rc(8'h20);
      // time-out: mode gating, routing, read clear
      u_host.w(8'h31, 8'h01);
      w(8'h20, 8'h91);
      tmo(1'b0);
      chk("flag", 0, flag);
      tmo(1'b1);
      chk("flag", 1, flag);
      chk("irq", 1, irq);
      u_host.r(8'h30, d);
      chk("status", 1, d[0]);
      chk("cfg cleared", 1, d[2]);
      @(posedge clk);
      #1;
      chk("irq", 0, irq);
      chk("flag", 0, flag);
      w(8'h20, 8'h81);
      tmo(1'b1);
      chk("irq", 0, irq);
      u_host.r(8'h30, d);
      // option write and trim reference need the unlock pattern
      u_host.w(8'h28, 8'h01);
      tx_pin <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("lp", 0, lp);
      chk("trim", 0, trim);
      w(8'h20, 8'hE1);
      u_host.w(8'h28, 8'h01);
      repeat (3) @(posedge clk);
      #1;
      chk("lp", 1, lp);
      chk("trim", 1, trim);
      @(posedge clk);
      tx_pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("trim", 0, trim);
      end_sim;
   end
   // hang guard
   initial begin
      #100000;
      err_count++;
      end_sim;
   end
endmodule
